// file: shared/acs_pkg.sv
// Purpose: Shared constants and types for the conversion sequencer.
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses.
// Notes:   Offsets are word aligned; reserved bits read as zero, except unused CTRL bits 15:0, which read back as written.
package acs_pkg;

   // Register byte offsets
   localparam logic [7:0] ACS_OFF_CTRL   = 8'h00;
   localparam logic [7:0] ACS_OFF_CMD    = 8'h04;
   localparam logic [7:0] ACS_OFF_SEL    = 8'h08;
   localparam logic [7:0] ACS_OFF_SAMP   = 8'h0c;
   localparam logic [7:0] ACS_OFF_FLAG   = 8'h10;
   localparam logic [7:0] ACS_OFF_RESULT = 8'h14;
   localparam logic [7:0] ACS_OFF_STATUS = 8'h18;

   // Control register fields
   localparam int ACS_CTRL_EN      = 0;
   localparam int ACS_CTRL_FREERUN = 1;
   localparam int ACS_CTRL_EVEN    = 2;
   localparam int ACS_CTRL_IRQEN   = 3;
   localparam int ACS_CTRL_GIE     = 4;
   localparam int ACS_CTRL_DIV_LSB = 8;
   localparam int ACS_CTRL_ACC_LSB = 12;
   // Selection register fields
   localparam int ACS_SEL_REF_LSB  = 8;
   // Sampling register fields
   localparam int ACS_SAMP_DLY_LSB = 8;

   // Reset values
   localparam logic [31:0] ACS_CTRL_RST = 32'h0000_0000;
   localparam logic [4:0]  ACS_CHAN_RST = 5'h00;
   localparam logic [2:0]  ACS_REF_RST  = 3'h0;

   // Conversion timing in conversion-clock cycles; full-scale code and accumulation cap
   localparam logic [5:0] ACS_CONV_CYC   = 6'h0d;
   localparam logic [5:0] ACS_SH_CYC     = 6'h02;
   localparam logic [9:0] ACS_FULL_SCALE = 10'h3ff;
   localparam logic [6:0] ACS_ACC_MAX    = 7'h40;

   typedef enum logic [1:0] {
      ACS_IDLE,
      ACS_WAIT,
      ACS_CONV
   } acs_state_t;

   // Selection carried to the analog core
   typedef struct packed {
      logic [2:0] ref_sel;
      logic [4:0] chan;
   } acs_sel_t;

   // Division factor 2^(sel+1): 2..256
   function automatic logic [8:0] acs_div_factor(input logic [2:0] sel);
      acs_div_factor = 9'h002 << sel;
   endfunction

   // Accumulation count 2^n, capped at 64
   function automatic logic [6:0] acs_acc_count(input logic [2:0] n);
      acs_acc_count = (n > 3'h6) ? ACS_ACC_MAX : (7'h01 << n);
   endfunction

endpackage

// file: logic/acs_sequencer.sv
// Purpose: Conversion sequencer for a 10-bit successive-approx converter.
// Assumes: Analog core holds its code valid in the last cycle; no done pulse.
// Notes:   One clock; prescaler held reset while idle or disabled.
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module acs_sequencer
   import acs_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        event_i,
   input  wire logic [9:0]  core_code_i,
   output acs_sel_t         core_sel_o,
   output logic             core_clk_o,
   output logic             core_sample_o,
   output logic             core_active_o,
   output logic             irq_o
);

   logic [31:0] ctrl_r;
   logic        start_r;
   acs_sel_t    hold_r;
   acs_sel_t    act_r;
   logic [7:0]  dly_r;
   logic [7:0]  len_r;
   logic        flag_r;
   logic [15:0] result_r;
   logic [15:0] acc_r;
   logic [6:0]  acc_cnt_r;
   logic [7:0]  pre_r;
   logic        cclk_r;
   logic [9:0]  cyc_r; // Ten bits: 13 + 255 + 255 overflows nine
   logic        event_d_r;
   acs_state_t  state_r;

   logic        enable;
   logic        wr;
   logic        rd;
   logic        cedge;
   logic        ev_rise;
   logic [9:0]  conv_len;
   logic        last_cyc;
   logic        done;
   logic        acc_last;
   logic [8:0]  div;

   assign enable   = ctrl_r[ACS_CTRL_EN];
   assign div      = acs_div_factor(ctrl_r[ACS_CTRL_DIV_LSB +: 3]);
   assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign rd       = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   assign ev_rise  = event_i && !event_d_r; // Edge sensitive trigger
   // Period stretched by delay and length fields
   assign conv_len = 10'(ACS_CONV_CYC) + 10'(dly_r) + 10'(len_r);
   assign last_cyc = (state_r == ACS_CONV) && cedge
                     && (cyc_r == conv_len - 10'h001);
   assign acc_last = (acc_cnt_r + 7'h01)
                     >= acs_acc_count(ctrl_r[ACS_CTRL_ACC_LSB +: 3]);
   assign done     = last_cyc && acc_last;

   // Wishbone ack, one cycle per access
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   // Read data mux; unmapped offsets read zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rd) begin
         case (wb_adr_i)
            ACS_OFF_CTRL:   wb_dat_o <= ctrl_r;
            ACS_OFF_CMD:    wb_dat_o <= {31'h0, start_r};
            ACS_OFF_SEL:    wb_dat_o <= {16'h0, 5'h0, hold_r.ref_sel,
                                         3'h0, hold_r.chan};
            ACS_OFF_SAMP:   wb_dat_o <= {16'h0, dly_r, len_r};
            ACS_OFF_FLAG:   wb_dat_o <= {31'h0, flag_r};
            ACS_OFF_RESULT: wb_dat_o <= {16'h0, result_r};
            ACS_OFF_STATUS: wb_dat_o <= {23'h0, act_r.ref_sel,
                                         act_r.chan, 1'b0};
            default:        wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // Software configuration registers, byte lane 0/1 writes
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_r <= ACS_CTRL_RST;
         hold_r <= '{ref_sel: ACS_REF_RST, chan: ACS_CHAN_RST};
         dly_r  <= 8'h00;
         len_r  <= 8'h00;
      end else if (wr) begin
         case (wb_adr_i)
            ACS_OFF_CTRL: begin
               if (wb_sel_i[0]) ctrl_r[7:0] <= wb_dat_i[7:0];
               if (wb_sel_i[1]) ctrl_r[15:8] <= wb_dat_i[15:8];
            end
            ACS_OFF_SEL: begin
               // Holding register; core sees act_r only
               if (wb_sel_i[0]) hold_r.chan <= wb_dat_i[4:0];
               if (wb_sel_i[1])
                  hold_r.ref_sel <= wb_dat_i[ACS_SEL_REF_LSB +: 3];
            end
            ACS_OFF_SAMP: begin
               if (wb_sel_i[0]) len_r <= wb_dat_i[7:0];
               if (wb_sel_i[1]) dly_r <= wb_dat_i[ACS_SAMP_DLY_LSB +: 8];
            end
            default: ;
         endcase
      end
   end

   // Start bit: software or event sets, completion clears in single
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         start_r <= 1'b0;
      end else if (!enable) begin
         start_r <= 1'b0;
      end else if ((wr && wb_adr_i == ACS_OFF_CMD && wb_sel_i[0]
                    && wb_dat_i[0])
                   || (ctrl_r[ACS_CTRL_EVEN] && ev_rise)) begin
         start_r <= 1'b1;
      end else if (done && !ctrl_r[ACS_CTRL_FREERUN]) begin
         start_r <= 1'b0;
      end
   end

   // Event edge detector
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         event_d_r <= 1'b0;
      end else begin
         event_d_r <= event_i;
      end
   end

   // Prescaler: half-period counter, reset while idle or disabled
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pre_r  <= 8'h00;
         cclk_r <= 1'b0;
      end else if (!enable || state_r == ACS_IDLE) begin
         pre_r  <= 8'h00;
         cclk_r <= 1'b0;
      end else if (pre_r == 8'(div[8:1] - 8'h01)) begin
         pre_r  <= 8'h00;
         cclk_r <= ~cclk_r;
      end else begin
         pre_r  <= pre_r + 8'h01;
      end
   end

   // Rising conversion-clock edge happens as the low half ends
   assign cedge = (state_r != ACS_IDLE) && !cclk_r
                  && (pre_r == 8'(div[8:1] - 8'h01));

   // Sequencer: wait for clock edge, then count conversion cycles
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= ACS_IDLE;
         cyc_r   <= 10'h000;
      end else if (!enable) begin
         state_r <= ACS_IDLE;
         cyc_r   <= 10'h000;
      end else begin
         case (state_r)
            ACS_IDLE: begin
               if (start_r) state_r <= ACS_WAIT;
            end
            ACS_WAIT: begin
               if (cedge) begin
                  state_r <= ACS_CONV;
                  cyc_r   <= 10'h000;
               end
            end
            ACS_CONV: begin
               // New starts ignored while running
               if (last_cyc) begin
                  cyc_r <= 10'h000;
                  if (!acc_last || ctrl_r[ACS_CTRL_FREERUN])
                     state_r <= ACS_CONV;
                  else
                     state_r <= ACS_IDLE;
               end else if (cedge) begin
                  cyc_r <= cyc_r + 10'h001;
               end
            end
            default: state_r <= ACS_IDLE;
         endcase
      end
   end

   // Active selection: copy unless converting, except last cycle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         act_r <= '{ref_sel: ACS_REF_RST, chan: ACS_CHAN_RST};
      end else if (enable && (state_r != ACS_CONV
                 || cyc_r == conv_len - 10'h001)) begin
         act_r <= hold_r;
      end
   end

   // Accumulator and result; done flag set wins over clear
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_r     <= 16'h0000;
         acc_cnt_r <= 7'h00;
         result_r  <= 16'h0000;
         flag_r    <= 1'b0;
      end else begin
         // Disable aborts a burst; stale partial sums must not leak
         if (!enable) begin
            acc_r     <= 16'h0000;
            acc_cnt_r <= 7'h00;
         end else if (last_cyc) begin
            // Core code already saturates at full scale
            acc_r     <= acc_last ? 16'h0000
                         : acc_r + {6'h00, core_code_i};
            acc_cnt_r <= acc_last ? 7'h00 : acc_cnt_r + 7'h01;
         end
         if (done) begin
            result_r <= acc_r + {6'h00, core_code_i};
            flag_r   <= 1'b1;
         end else if ((rd && wb_adr_i == ACS_OFF_RESULT)
                      || (wr && wb_adr_i == ACS_OFF_FLAG
                          && wb_sel_i[0] && wb_dat_i[0])) begin
            flag_r <= 1'b0;
         end
      end
   end

   // Core-facing outputs and interrupt
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         core_sample_o <= 1'b0;
         core_active_o <= 1'b0;
         irq_o         <= 1'b0;
      end else begin
         core_active_o <= (state_r == ACS_CONV);
         // Hold window ends at 2 + delay + length
         core_sample_o <= (state_r == ACS_CONV) && (cyc_r <
                          10'(ACS_SH_CYC) + 10'(dly_r) + 10'(len_r));
         irq_o <= flag_r && ctrl_r[ACS_CTRL_IRQEN]
                  && ctrl_r[ACS_CTRL_GIE];
      end
   end

   assign core_clk_o = cclk_r;
   assign core_sel_o = act_r;

   // Assertions
   property p_flag_on_done;
      @(posedge clk_i) disable iff (rst_i) done |=> flag_r;
   endproperty
   a_flag_on_done: assert property (p_flag_on_done)
      else $error("flag not set after done");

   property p_irq_gate;
      @(posedge clk_i) disable iff (rst_i)
         irq_o |-> $past(ctrl_r[ACS_CTRL_IRQEN] && ctrl_r[ACS_CTRL_GIE]);
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("irq without both enables");

   property p_start_held;
      @(posedge clk_i) disable iff (rst_i)
         (state_r == ACS_CONV && !done && enable) |=> start_r;
   endproperty
   a_start_held: assert property (p_start_held)
      else $error("start bit dropped mid conversion");

   property p_single_clear;
      @(posedge clk_i) disable iff (rst_i)
         (done && !ctrl_r[ACS_CTRL_FREERUN] && !wr && !ev_rise)
         |=> !start_r;
   endproperty
   a_single_clear: assert property (p_single_clear)
      else $error("start bit not cleared");

   property p_sel_frozen;
      @(posedge clk_i) disable iff (rst_i)
         (state_r == ACS_CONV && cyc_r != conv_len - 10'h001
          && $past(state_r) == ACS_CONV) |=> $stable(act_r);
   endproperty
   a_sel_frozen: assert property (p_sel_frozen)
      else $error("selection changed during conversion");

   property p_pre_idle;
      @(posedge clk_i) disable iff (rst_i)
         !enable |=> pre_r == 8'h00;
   endproperty
   a_pre_idle: assert property (p_pre_idle)
      else $error("prescaler ran while disabled");

   property p_freerun;
      @(posedge clk_i) disable iff (rst_i)
         (last_cyc && ctrl_r[ACS_CTRL_FREERUN] && enable)
         |=> state_r == ACS_CONV && cyc_r == 10'h000;
   endproperty
   a_freerun: assert property (p_freerun)
      else $error("free run did not relaunch");

   property p_cyc_bound;
      @(posedge clk_i) disable iff (rst_i)
         state_r == ACS_CONV |-> cyc_r < conv_len;
   endproperty
   a_cyc_bound: assert property (p_cyc_bound)
      else $error("conversion overran its length");

   property p_event_start;
      @(posedge clk_i) disable iff (rst_i)
         (enable && ctrl_r[ACS_CTRL_EVEN] && ev_rise) |=> start_r;
   endproperty
   a_event_start: assert property (p_event_start)
      else $error("event did not set start bit");

   // Trigger seen while idle; prescaler origin keeps start delay fixed
   sequence s_launch;
      state_r == ACS_IDLE && start_r && enable;
   endsequence

   sequence s_first_edge;
      state_r == ACS_WAIT && cedge && enable;
   endsequence

   property p_start_origin;
      @(posedge clk_i) disable iff (rst_i)
         s_launch |=> state_r == ACS_WAIT && pre_r == 8'h00 && !cclk_r;
   endproperty
   a_start_origin: assert property (p_start_origin)
      else $error("conversion wait began off the prescaler origin");

   property p_window_opens;
      @(posedge clk_i) disable iff (rst_i)
         s_first_edge |=> ##1 (core_sample_o && core_active_o);
   endproperty
   a_window_opens: assert property (p_window_opens)
      else $error("sampling window did not open at conversion start");

   property p_flag_read_clear;
      @(posedge clk_i) disable iff (rst_i)
         (rd && wb_adr_i == ACS_OFF_RESULT && !done) |=> !flag_r;
   endproperty
   a_flag_read_clear: assert property (p_flag_read_clear)
      else $error("result read left the done flag set");

   property p_sel_idle_disabled;
      @(posedge clk_i) disable iff (rst_i)
         !enable |=> $stable(act_r);
   endproperty
   a_sel_idle_disabled: assert property (p_sel_idle_disabled)
      else $error("selection moved while disabled");

endmodule

// file: tb/acs_core_model.sv
// Purpose: Analog core stand-in facing the conversion sequencer.
// Assumes: Code is taken when the sampling window closes.
// Notes:   Idle code lines show the inverted code, never a stale copy.
`timescale 1ns/1ps
module acs_core_model
   import acs_pkg::*;
(
   input  wire logic       clk_i,
   input  wire acs_sel_t   sel_i,
   input  wire logic       sample_i,
   input  wire logic       active_i,
   output logic      [9:0] code_o
);
   logic [9:0] held_r = 10'h155;
   logic       samp_r = 1'b0;

   // Ideal code: 150 mV per channel step, 600 mV per reference step
   function automatic logic [9:0] code_of(input acs_sel_t s);
      int vin;
      int vref;
      vin  = s.chan * 150;
      vref = (s.ref_sel + 1) * 600;
      if (vin >= vref)
         code_of = 10'h3ff;
      else
         code_of = 10'((1023 * vin + vref / 2) / vref);
   endfunction

   // Hold the input at the close of the sampling window
   always @(posedge clk_i) begin
      samp_r <= sample_i;
      if (samp_r && !sample_i)
         held_r <= code_of(sel_i);
   end

   // Inverted when idle so a late sample cannot pass by luck
   assign code_o = active_i ? held_r : ~held_r;
endmodule

// file: tb/acs_sequencer_tb.sv
// Purpose: Self-checking bench for the conversion sequencer.
// Assumes: Wishbone classic master tasks, seeded random setups.
// Notes:   Window lengths are measured at the core-side outputs.
`timescale 1ns/1ps
module acs_sequencer_tb
   import acs_pkg::*;
;
   logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, event_i;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_wdat, wb_rdat, q;
   logic        wb_ack, core_clk, core_samp, core_act, irq;
   logic [9:0]  code;
   acs_sel_t    core_sel, old_sel, new_sel;
   logic        ie, gie, samp_q = 1'b0, act_q = 1'b0;
   int          seed, mismatches, compares, cyc_n, t_last, t_prev, n0;
   int          nrise, act_len, samp_len, act_cnt, samp_cnt, n;
   int          d, l, ds, div, acc;

   acs_sequencer acs_sequencer_i (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .event_i(event_i),
      .core_code_i(code), .core_sel_o(core_sel), .core_clk_o(core_clk),
      .core_sample_o(core_samp), .core_active_o(core_act), .irq_o(irq));
   acs_core_model acs_core_model_i (.clk_i(clk_i), .sel_i(core_sel),
      .sample_i(core_samp), .active_i(core_act), .code_o(code));

   always #4 clk_i = ~clk_i;

   // Stamps of window starts and lengths of finished windows
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      samp_q <= core_samp;
      act_q <= core_act;
      samp_cnt <= core_samp ? samp_cnt + 1 : 0;
      act_cnt <= core_act ? act_cnt + 1 : 0;
      if (core_samp && !samp_q) begin
         t_prev <= t_last;
         t_last <= cyc_n;
         nrise <= nrise + 1;
      end
      if (!core_samp && samp_q)
         samp_len <= samp_cnt;
      if (!core_act && act_q)
         act_len <= act_cnt;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One classic cycle; held until ack is seen at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] dv);
      int k;
      k = 0;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_sel <= 4'h3;
      wb_adr <= a;
      wb_wdat <= dv;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack !== 1'b1 && k < 200);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (k >= 200)
         chk(32'h0, 32'h1);
   endtask

   task automatic wait_flag();
      n = 0;
      do begin
         xfer(1'b0, ACS_OFF_FLAG, 32'h0);
         n++;
      end while (q[0] !== 1'b1 && n < 2000);
      chk(q[0], 1'b1);
   endtask

   task automatic pulse();
      event_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      event_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic final_report();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Watchdog well beyond the longest expected run
   initial begin
      repeat (60000) @(posedge clk_i);
      mismatches++;
      final_report();
   end

   initial begin
      seed = 32'h2001;
      clk_i = 1'b0;
      rst_i = 1'b1;
      {wb_cyc, wb_stb, wb_we, event_i} = 4'h0;
      wb_adr = 8'h00;
      wb_sel = 4'h3;
      wb_wdat = 32'h0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      xfer(1'b0, ACS_OFF_CTRL, 32'h0);
      chk(q, ACS_CTRL_RST);
      xfer(1'b0, 8'hfc, 32'h0);
      chk(q, 32'h0);
      xfer(1'b1, ACS_OFF_SEL, 32'h103);
      repeat (4) @(posedge clk_i);
      chk(core_sel, {ACS_REF_RST, ACS_CHAN_RST});
      xfer(1'b1, ACS_OFF_CTRL, 32'h1);
      repeat (4) @(posedge clk_i);
      chk(core_sel, 8'h23);
      xfer(1'b0, ACS_OFF_STATUS, 32'h0);
      chk(q, 32'h0000_0046);
      $display("test select done");
      // Single conversions, random setup, selection moved mid-run except in accumulation runs
      for (int i = 0; i < 6; i++) begin
         d = $unsigned($random(seed)) % 8;
         l = $unsigned($random(seed)) % 8;
         ds = $unsigned($random(seed)) % 4;
         div = 2 << ds;
         acc = (i % 3 == 2) ? 2 : 0;
         ie = 1'($random(seed));
         gie = 1'($random(seed));
         old_sel.chan = 5'($unsigned($random(seed)) % 12);
         old_sel.ref_sel = 3'($unsigned($random(seed)) % 5);
         new_sel = (acc == 0) ? old_sel ^ 8'h21 : old_sel;
         xfer(1'b1, ACS_OFF_SAMP, {16'h0, 8'(d), 8'(l)});
         xfer(1'b1, ACS_OFF_SEL, {21'h0, old_sel.ref_sel, 3'h0, old_sel.chan});
         xfer(1'b1, ACS_OFF_CTRL,
              {17'h0, 3'(acc), 1'b0, 3'(ds), 3'h0, gie, ie, 3'h1});
         xfer(1'b1, ACS_OFF_CMD, 32'h1);
         xfer(1'b0, ACS_OFF_CMD, 32'h0);
         chk(q[0], 1'b1);
         n = 0;
         while (core_act !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
         end
         xfer(1'b1, ACS_OFF_SEL, {21'h0, new_sel.ref_sel, 3'h0, new_sel.chan});
         chk(core_sel, old_sel);
         wait_flag();
         chk(irq, ie & gie);
         xfer(1'b0, ACS_OFF_CMD, 32'h0);
         chk(q[0], 1'b0);
         if (acc == 0) begin
            chk(act_len, (13 + d + l) * div);
            chk(samp_len, (2 + d + l) * div);
         end
         if (i % 2) begin
            xfer(1'b1, ACS_OFF_FLAG, 32'h1);
            xfer(1'b0, ACS_OFF_FLAG, 32'h0);
            chk(q[0], 1'b0);
         end
         xfer(1'b0, ACS_OFF_RESULT, 32'h0);
         chk(q, 32'(acs_core_model_i.code_of(old_sel)) << acc);
         xfer(1'b0, ACS_OFF_FLAG, 32'h0);
         chk(q[0], 1'b0);
         chk(core_sel, new_sel);
         $display("test single %0d done", i);
      end
      // Event starts: ignored while event enable is clear, one per held pulse, edge while running ignored
      xfer(1'b1, ACS_OFF_SAMP, 32'h0);
      xfer(1'b1, ACS_OFF_CTRL, 32'h1);
      n0 = nrise;
      pulse();
      repeat (40) @(posedge clk_i);
      chk(nrise, n0);
      xfer(1'b1, ACS_OFF_CTRL, 32'h5);
      pulse();
      xfer(1'b0, ACS_OFF_CMD, 32'h0);
      chk(q[0], 1'b1);
      pulse();
      wait_flag();
      xfer(1'b0, ACS_OFF_CMD, 32'h0);
      chk(q[0], 1'b0);
      repeat (40) @(posedge clk_i);
      chk(nrise, n0 + 1);
      xfer(1'b0, ACS_OFF_RESULT, 32'h0);
      $display("test event done");
      // Free-running: back-to-back windows at the full period
      d = $unsigned($random(seed)) % 8;
      l = $unsigned($random(seed)) % 8;
      xfer(1'b1, ACS_OFF_SAMP, {16'h0, 8'(d), 8'(l)});
      xfer(1'b1, ACS_OFF_CTRL, 32'h103);
      n0 = nrise;
      xfer(1'b1, ACS_OFF_CMD, 32'h1);
      n = 0;
      while (nrise < n0 + 3 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      chk(t_last - t_prev, (13 + d + l) * 4);
      xfer(1'b0, ACS_OFF_FLAG, 32'h0);
      chk(q[0], 1'b1);
      xfer(1'b1, ACS_OFF_CTRL, 32'h0);
      repeat (4) @(posedge clk_i);
      chk({core_clk, core_act}, 2'b00);
      $display("test freerun done");
      final_report();
   end
endmodule
